// [verilog/tcr_top.sv]
// Trace control registers: mode gating, content selection, capabilities and user trace records.
`timescale 1ns/100ps
module tcr_top #(
	parameter bit HAS_TRACE = 1'b1
) (
	// Clock and reset
	input  wire                          clk_sys,
	input  wire                          nrst,
	// Coprocessor register port
	input  wire logic [2:0]              reg_sel,
	input  wire                          reg_wr,
	input  wire logic [31:0]             reg_wdata,
	input  wire                          reg_rd,
	output logic [31:0]                  reg_rdata,
	// Core state
	input  wire tcr_pkg::tcr_exec_e      exec_mode,
	input  wire                          instr_step,
	// Trace collector block
	input  wire tcr_pkg::tcr_ctrl_s      coll_ctrl,
	input  wire tcr_pkg::tcr_caps_s      coll_caps,
	input  wire                          coll_caps_vld,
	// Trace outputs
	output logic                         trace_active,
	output tcr_pkg::tcr_mode_e           trace_mode,
	output logic                         trace_branch_all,
	output logic                         trace_no_ovf,
	output logic                         trace_sync,
	output tcr_pkg::tcr_urec_s           user_rec
);
	typedef struct packed {
		logic               src_sel;
		logic               user_kind;
		tcr_pkg::tcr_ctrl_s sw;
		tcr_pkg::tcr_caps_s caps;
		logic [31:0]        word;
		logic [31:0]        rdata;
		tcr_pkg::tcr_urec_s urec;
		logic               active;
		tcr_pkg::tcr_mode_e mode;
		logic               branch_all;
		logic               no_ovf;
	} tcr_state_s;

	tcr_state_s         st_r;
	tcr_state_s         st_nxt;
	tcr_pkg::tcr_ctrl_s eff;
	logic               permit;
	logic               word_wr;

	// Read image of trace_config; bit 4 reads as one, other gaps read as zero.
	function automatic logic [31:0] tcr_cfg_img(input tcr_state_s s);
		logic [31:0] v;
		v = tcr_pkg::ZERO_WORD;
		v[tcr_pkg::CFG_SRC_SEL]   = s.src_sel;
		v[tcr_pkg::CFG_USER_KIND] = s.user_kind;
		v[tcr_pkg::CFG_BRANCH]    = s.sw.branch_all;
		v[tcr_pkg::CFG_NO_OVF]    = s.sw.no_ovf;
		v[tcr_pkg::CFG_EN_DEBUG]  = s.sw.en_debug;
		v[tcr_pkg::CFG_EN_EXC]    = s.sw.en_exc;
		v[tcr_pkg::CFG_EN_KERNEL] = s.sw.en_kernel;
		v[tcr_pkg::CFG_EN_USER]   = s.sw.en_user;
		v[tcr_pkg::CFG_ONE_BIT]   = 1'b1;
		v[tcr_pkg::CFG_MODE_HI:tcr_pkg::CFG_MODE_LO] = s.sw.mode;
		v[tcr_pkg::CFG_ON]        = s.sw.on;
		tcr_cfg_img = v;
	endfunction

	// Read image of trace_config_ext; everything above bit 6 is zero.
	function automatic logic [31:0] tcr_ext_img(input tcr_pkg::tcr_caps_s c);
		logic [31:0] v;
		v = tcr_pkg::ZERO_WORD;
		v[tcr_pkg::EXT_LVL_HI:tcr_pkg::EXT_LVL_LO] = c.levels;
		v[tcr_pkg::EXT_DUAL]                       = c.dual_buffer_present;
		v[tcr_pkg::EXT_OFFCHIP]                    = c.offchip_buffer_selected;
		v[tcr_pkg::EXT_SYP_HI:tcr_pkg::EXT_SYP_LO] = c.sync_period_code;
		tcr_ext_img = v;
	endfunction

	// The collector may override the software bits, so the gate sees the chosen set.
	always_comb begin
		eff = st_r.src_sel ? st_r.sw : coll_ctrl;
	end

	tcr_permit u_permit (
		.ctrl      (eff),
		.exec_mode (exec_mode),
		.permit    (permit)
	);

	tcr_sync u_sync (
		.clk_sys    (clk_sys),
		.nrst       (nrst),
		.active     (st_r.active),
		.step       (instr_step),
		.offchip    (st_r.caps.offchip_buffer_selected),
		.code       (st_r.caps.sync_period_code),
		.sync_pulse (trace_sync)
	);

	assign word_wr = reg_wr && (reg_sel == tcr_pkg::SEL_USER_WORD) && HAS_TRACE;

	always_comb begin
		st_nxt = st_r;
		st_nxt.urec.valid = 1'b0;

		// Software writes to trace_config.
		if (reg_wr && reg_sel == tcr_pkg::SEL_CONFIG) begin
			st_nxt.src_sel      = reg_wdata[tcr_pkg::CFG_SRC_SEL];
			st_nxt.user_kind    = reg_wdata[tcr_pkg::CFG_USER_KIND];
			st_nxt.sw.branch_all = reg_wdata[tcr_pkg::CFG_BRANCH];
			st_nxt.sw.no_ovf    = reg_wdata[tcr_pkg::CFG_NO_OVF];
			st_nxt.sw.en_debug  = reg_wdata[tcr_pkg::CFG_EN_DEBUG];
			st_nxt.sw.en_exc    = reg_wdata[tcr_pkg::CFG_EN_EXC];
			st_nxt.sw.en_kernel = reg_wdata[tcr_pkg::CFG_EN_KERNEL];
			st_nxt.sw.en_user   = reg_wdata[tcr_pkg::CFG_EN_USER];
			st_nxt.sw.mode      = tcr_pkg::tcr_mode_e'(reg_wdata[tcr_pkg::CFG_MODE_HI:tcr_pkg::CFG_MODE_LO]);
			st_nxt.sw.on        = reg_wdata[tcr_pkg::CFG_ON];
		end

		// Writes to the extension register are dropped; its fields follow the collector.
		if (coll_caps_vld) begin
			st_nxt.caps = coll_caps;
		end

		// A user word write stores the value and launches one record the next cycle.
		// Back-to-back writes need no spacing: each one launches its own record, on consecutive cycles.
		if (word_wr) begin
			st_nxt.word       = reg_wdata;
			st_nxt.urec.valid = 1'b1;
			st_nxt.urec.kind2 = st_r.user_kind;
			st_nxt.urec.data  = reg_wdata;
		end

		// Registered trace controls toward the trace logic.
		st_nxt.active     = permit;
		st_nxt.mode       = eff.mode;
		st_nxt.branch_all = eff.branch_all;
		st_nxt.no_ovf     = eff.no_ovf;

		// Registered read data; unmapped selects read zero.
		if (reg_rd) begin
			unique case (reg_sel)
				tcr_pkg::SEL_CONFIG:     st_nxt.rdata = tcr_cfg_img(st_r);
				tcr_pkg::SEL_CONFIG_EXT: st_nxt.rdata = tcr_ext_img(st_r.caps);
				tcr_pkg::SEL_USER_WORD:  st_nxt.rdata = HAS_TRACE ? st_r.word : tcr_pkg::ZERO_WORD;
				default:                 st_nxt.rdata = tcr_pkg::ZERO_WORD;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			st_r               <= '0;
			st_r.sw.mode       <= tcr_pkg::tcr_mode_e'(tcr_pkg::MODE_RESET);
			st_r.caps.levels   <= tcr_pkg::LVL_RESET;
			st_r.caps.sync_period_code <= tcr_pkg::SYP_RESET;
			st_r.word          <= tcr_pkg::WORD_RESET;
			st_r.mode          <= tcr_pkg::TM_PC;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata        = st_r.rdata;
	assign trace_active     = st_r.active;
	assign trace_mode       = st_r.mode;
	assign trace_branch_all = st_r.branch_all;
	assign trace_no_ovf     = st_r.no_ovf;
	assign user_rec         = st_r.urec;
endmodule

// [verilog/tcr_pkg.sv]
// Package with constants, field layout and carrier types for the trace control registers.
package tcr_pkg;

	// Register selects on the coprocessor register port.
	localparam logic [2:0] SEL_CONFIG     = 3'h1;
	localparam logic [2:0] SEL_CONFIG_EXT = 3'h2;
	localparam logic [2:0] SEL_USER_WORD  = 3'h3;

	// Field positions in trace_config.
	localparam int CFG_SRC_SEL   = 31;
	localparam int CFG_USER_KIND = 30;
	localparam int CFG_BRANCH    = 27;
	localparam int CFG_NO_OVF    = 26;
	localparam int CFG_EN_DEBUG  = 25;
	localparam int CFG_EN_EXC    = 24;
	localparam int CFG_EN_KERNEL = 23;
	localparam int CFG_EN_USER   = 21;
	localparam int CFG_ONE_BIT   = 4;
	localparam int CFG_MODE_HI   = 3;
	localparam int CFG_MODE_LO   = 1;
	localparam int CFG_ON        = 0;

	// Field positions in trace_config_ext.
	localparam int EXT_LVL_HI  = 6;
	localparam int EXT_LVL_LO  = 5;
	localparam int EXT_DUAL    = 4;
	localparam int EXT_OFFCHIP = 3;
	localparam int EXT_SYP_HI  = 2;
	localparam int EXT_SYP_LO  = 0;

	// Reset and fixed values.
	localparam logic [1:0]  LVL_RESET   = 2'h2;
	localparam logic [2:0]  SYP_RESET   = 3'h0;
	localparam logic [2:0]  MODE_RESET  = 3'h0;
	localparam logic [31:0] WORD_RESET  = 32'h0000_0000;
	localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

	// Synchronization period exponents for code zero; each code step halves the period.
	localparam logic [3:0] SYP_EXP_ON_BASE  = 4'h9;
	localparam logic [3:0] SYP_EXP_OFF_BASE = 4'he;
	localparam int         SYP_CNT_W        = 15;

	// Trace content selection.
	typedef enum logic [2:0] {
		TM_PC        = 3'b000,
		TM_LD_ADDR   = 3'b001,
		TM_ST_ADDR   = 3'b010,
		TM_LS_ADDR   = 3'b011,
		TM_LD_DATA   = 3'b100,
		TM_LD_AD     = 3'b101,
		TM_ST_AD     = 3'b110,
		TM_ALL       = 3'b111
	} tcr_mode_e;

	// Execution mode of the core.
	typedef enum logic [1:0] {
		EM_USER   = 2'b00,
		EM_KERNEL = 2'b01,
		EM_EXC    = 2'b10,
		EM_DEBUG  = 2'b11
	} tcr_exec_e;

	// Trace control bits, from software or from the collector block.
	typedef struct packed {
		logic      on;
		tcr_mode_e mode;
		logic      en_user;
		logic      en_kernel;
		logic      en_exc;
		logic      en_debug;
		logic      no_ovf;
		logic      branch_all;
	} tcr_ctrl_s;

	// Capability and status fields supplied by the collector block.
	typedef struct packed {
		logic [1:0] levels;
		logic       dual_buffer_present;
		logic       offchip_buffer_selected;
		logic [2:0] sync_period_code;
	} tcr_caps_s;

	// User trace record toward the collector.
	typedef struct packed {
		logic        valid;
		logic        kind2;
		logic [31:0] data;
	} tcr_urec_s;

endpackage

// [verilog/tcr_permit.sv]
// Mode gate that decides whether the current execution mode may be traced.
`timescale 1ns/100ps
module tcr_permit (
	// Effective control
	input  wire tcr_pkg::tcr_ctrl_s ctrl,
	input  wire tcr_pkg::tcr_exec_e exec_mode,
	// Result
	output logic                    permit
);
	logic mode_en;

	always_comb begin
		unique case (exec_mode)
			tcr_pkg::EM_USER:   mode_en = ctrl.en_user;
			tcr_pkg::EM_KERNEL: mode_en = ctrl.en_kernel;
			tcr_pkg::EM_EXC:    mode_en = ctrl.en_exc;
			tcr_pkg::EM_DEBUG:  mode_en = ctrl.en_debug;
		endcase
		// The master enable alone traces nothing; a mode enable must agree.
		permit = ctrl.on & mode_en;
	end
endmodule

// [verilog/tcr_sync.sv]
// Synchronization period timer that pulses once per decoded period of traced instructions.
`timescale 1ns/100ps
module tcr_sync (
	// Clock and reset
	input  wire                  clk_sys,
	input  wire                  nrst,
	// Control
	input  wire                  active,
	input  wire                  step,
	input  wire                  offchip,
	input  wire logic [2:0]      code,
	// Pulse out
	output logic                 sync_pulse
);
	typedef struct packed {
		logic [tcr_pkg::SYP_CNT_W-1:0] cnt;
		logic                          pulse;
	} tcr_sync_s;

	tcr_sync_s st_r;
	tcr_sync_s st_nxt;
	logic [tcr_pkg::SYP_CNT_W-1:0] last;

	// Exponent of the period: the base falls by one per code step.
	function automatic logic [3:0] tcr_exp(input logic off, input logic [2:0] c);
		tcr_exp = (off ? tcr_pkg::SYP_EXP_OFF_BASE : tcr_pkg::SYP_EXP_ON_BASE) - {1'b0, c};
	endfunction

	always_comb begin
		last = ({{(tcr_pkg::SYP_CNT_W-1){1'b0}}, 1'b1} << tcr_exp(offchip, code)) - 1'b1;
		st_nxt = st_r;
		st_nxt.pulse = 1'b0;
		if (!active) begin
			st_nxt.cnt = '0;
		end else if (step) begin
			if (st_r.cnt >= last) begin
				st_nxt.cnt = '0;
				st_nxt.pulse = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_pulse = st_r.pulse;
endmodule

// [tb/tcr_assertions.sv]
// Checker for the trace control register outputs.
`timescale 1ns/100ps
module tcr_chk (
	// Clock and reset
	input wire                     clk_sys,
	input wire                     nrst,
	// Register port
	input wire logic [2:0]         reg_sel,
	input wire                     reg_wr,
	input wire logic [31:0]        reg_wdata,
	input wire                     reg_rd,
	input wire logic [31:0]        reg_rdata,
	// Core state and outputs
	input wire tcr_pkg::tcr_exec_e exec_mode,
	input wire tcr_pkg::tcr_ctrl_s coll_ctrl,
	input wire                     trace_active,
	input wire tcr_pkg::tcr_mode_e trace_mode,
	input wire                     trace_sync,
	input wire tcr_pkg::tcr_urec_s user_rec
);
	logic [31:0] cfg_r;
	logic [9:0]  ec;
	logic [3:0]  en;
	logic        exp_act;
	// Shadow of the config register, so gating can be predicted from the port alone.
	always_ff @(posedge clk_sys) begin
		if (!nrst)
			cfg_r <= 32'h0;
		else if (reg_wr && reg_sel == tcr_pkg::SEL_CONFIG)
			cfg_r <= reg_wdata;
	end
	always_comb begin
		ec = cfg_r[31] ? {cfg_r[0], cfg_r[3:1], cfg_r[21], cfg_r[23], cfg_r[24], cfg_r[25], cfg_r[26], cfg_r[27]} : coll_ctrl;
		en = {ec[2], ec[3], ec[4], ec[5]};
		exp_act = ec[9] && en[exec_mode];
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	rst_clears_out_a: assert property (disable iff (1'b0) !nrst |=> reg_rdata == 32'h0 && !trace_active && !user_rec.valid)
		else $error("outputs not cleared by reset");
	rec_cause_a: assert property (user_rec.valid |-> $past(reg_wr && reg_sel == tcr_pkg::SEL_USER_WORD))
		else $error("user record without a write");
	rec_data_a: assert property (reg_wr && reg_sel == tcr_pkg::SEL_USER_WORD |=> user_rec.valid && user_rec.data == $past(reg_wdata))
		else $error("user record missing or data wrong");
	rec_kind_a: assert property (user_rec.valid |-> user_rec.kind2 == cfg_r[30])
		else $error("user record kind wrong");
	ext_high_zero_a: assert property (reg_rd && reg_sel == tcr_pkg::SEL_CONFIG_EXT |=> reg_rdata[31:7] == 25'h0)
		else $error("ext upper bits not zero");
	rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
		else $error("read data changed without a read");
	sync_single_a: assert property (trace_sync |=> !trace_sync [*3])
		else $error("sync pulses too close");
	gate_match_a: assert property ($past(nrst, 2) && $past({exp_act, ec[8:6]}) == {exp_act, ec[8:6]} |-> trace_active == exp_act && (!exp_act || trace_mode == ec[8:6]))
		else $error("trace gating wrong");
	cover property (user_rec.valid);
	cover property (trace_sync);
	cover property (trace_active && exec_mode == tcr_pkg::EM_DEBUG);
endmodule
bind tcr_top tcr_chk u_tcr_chk (.clk_sys, .nrst, .reg_sel, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .exec_mode,
	.coll_ctrl, .trace_active, .trace_mode, .trace_sync, .user_rec);

// [tb/tcr_coll_model.sv]
// Trace collector model: supplies control and capability fields and gathers user records.
`timescale 1ns/100ps
module tcr_coll_model (
	// Clock and reset
	input wire                     clk_sys,
	input wire                     nrst,
	// Commands from the bench
	input wire tcr_pkg::tcr_ctrl_s ctrl_cmd,
	input wire tcr_pkg::tcr_caps_s caps_cmd,
	input wire                     load,
	// Block side
	output tcr_pkg::tcr_ctrl_s     coll_ctrl,
	output tcr_pkg::tcr_caps_s     coll_caps,
	output logic                   coll_caps_vld,
	input wire tcr_pkg::tcr_urec_s user_rec,
	// Gathered records
	output int                     n_rec
);
	always_ff @(posedge clk_sys) begin
		coll_ctrl <= ctrl_cmd;
		coll_caps_vld <= nrst && load;
		// Fields flip while not valid, so a block that samples them then is caught.
		coll_caps <= !nrst ? '0 : load ? caps_cmd : ~coll_caps;
		if (!nrst)
			n_rec <= 0;
		else if (user_rec.valid)
			n_rec <= n_rec + 1;
	end
endmodule

// [tb/test_tcr_top.sv]
// Testbench for the trace control registers.
`timescale 1ns/100ps
module test_tcr_top;
	logic clk_sys, nrst, reg_wr, reg_rd, instr_step, load, trace_active, trace_branch_all, trace_no_ovf, trace_sync;
	logic [2:0]  reg_sel;
	logic [31:0] reg_wdata, reg_rdata, d, w;
	logic [9:0]  c;
	tcr_pkg::tcr_exec_e exec_mode;
	tcr_pkg::tcr_ctrl_s ctrl_cmd, coll_ctrl;
	tcr_pkg::tcr_caps_s caps_cmd, coll_caps;
	tcr_pkg::tcr_mode_e trace_mode;
	tcr_pkg::tcr_urec_s user_rec;
	logic coll_caps_vld;
	int n_fail, tests_run, n_rec, n, per;
	tcr_top u_tcr_top (.clk_sys, .nrst, .reg_sel, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .exec_mode, .instr_step,
		.coll_ctrl, .coll_caps, .coll_caps_vld, .trace_active, .trace_mode, .trace_branch_all, .trace_no_ovf,
		.trace_sync, .user_rec);
	tcr_coll_model u_tcr_coll_model (.clk_sys, .nrst, .ctrl_cmd, .caps_cmd, .load, .coll_ctrl, .coll_caps,
		.coll_caps_vld, .user_rec, .n_rec);
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// Wide enough that a whole user record, valid and kind bits included, is compared.
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] expv);
		tests_run++;
		if (seen !== expv) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, expv, seen);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Every write leaves one idle cycle behind it, so user words never land back to back.
	task automatic wr(input logic [2:0] s, input logic [31:0] v);
		@(posedge clk_sys);
		reg_sel <= s;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] s);
		@(posedge clk_sys);
		reg_sel <= s;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask
	task automatic caps(input logic [6:0] v);
		@(posedge clk_sys);
		caps_cmd <= v;
		load <= 1'b1;
		@(posedge clk_sys);
		load <= 1'b0;
	endtask
	initial begin
		repeat (60000) @(posedge clk_sys);
		n_fail++;
		end_of_test;
	end
	initial begin
		{nrst, reg_wr, reg_rd, instr_step, load, reg_sel, reg_wdata} = '0;
		exec_mode = tcr_pkg::EM_USER;
		ctrl_cmd = '0;
		caps_cmd = '0;
		void'($urandom(41412));
		repeat (6) @(posedge clk_sys);
		nrst <= 1'b1;
		rd(tcr_pkg::SEL_CONFIG_EXT);
		chk("ext reset", d, 32'h40);
		rd(tcr_pkg::SEL_CONFIG);
		chk("cfg reset", d, 32'h10);
		rd(tcr_pkg::SEL_USER_WORD);
		chk("word reset", d, 32'h0);
		rd(3'h5);
		chk("unmapped", d, 32'h0);
		for (int i = 0; i < 6; i++) begin
			w = $urandom;
			caps(w[6:0]);
			wr(tcr_pkg::SEL_CONFIG_EXT, ~w);
			rd(tcr_pkg::SEL_CONFIG_EXT);
			chk("ext caps", d, {25'h0, w[6:0]});
		end
		for (int i = 0; i < 32; i++) begin
			w = $urandom;
			w[3:1] = i[2:0];
			@(posedge clk_sys);
			exec_mode <= tcr_pkg::tcr_exec_e'(i[4:3]);
			ctrl_cmd <= tcr_pkg::tcr_ctrl_s'(10'($urandom));
			wr(tcr_pkg::SEL_CONFIG, w);
			rd(tcr_pkg::SEL_CONFIG);
			chk("cfg", d, (w & 32'hcfa0_000f) | 32'h10);
			c = w[31] ? {w[0], w[3:1], w[21], w[23], w[24], w[25], w[26], w[27]} : ctrl_cmd;
			chk("active", trace_active, c[9] && c[5 - i[4:3]]);
			chk("mode", trace_mode, c[8:6]);
			chk("ovf", {trace_no_ovf, trace_branch_all}, c[1:0]);
		end
		for (int k = 0; k < 4; k++) begin
			wr(tcr_pkg::SEL_CONFIG, {1'b1, k[0], 30'h0});
			w = $urandom;
			wr(tcr_pkg::SEL_USER_WORD, w);
			@(negedge clk_sys);
			chk("record", user_rec, {1'b1, k[0], w});
			rd(tcr_pkg::SEL_USER_WORD);
			chk("word", d, w);
		end
		chk("records", n_rec, 4);
		@(posedge clk_sys);
		exec_mode <= tcr_pkg::EM_USER;
		for (int i = 0; i < 12; i++) begin
			wr(tcr_pkg::SEL_CONFIG, 32'h0);
			caps({3'h4, i > 7, i > 7 ? 3'(i - 4) : 3'(i)});
			wr(tcr_pkg::SEL_CONFIG, 32'h8020_0001);
			instr_step <= 1'b1;
			// Pulses are looked at on the falling edge, where the registered output has settled.
			n = 0;
			do begin
				@(negedge clk_sys);
				n++;
			end while (!trace_sync && n < 20000);
			if (n >= 20000)
				n_fail++;
			per = 0;
			do begin
				@(negedge clk_sys);
				per++;
			end while (!trace_sync && per < 20000);
			@(posedge clk_sys);
			instr_step <= 1'b0;
			chk("sync period", per, i > 7 ? 1 << (18 - i) : 1 << (9 - i));
		end
		end_of_test;
	end
endmodule
